// ---- hw/pac_pkg.sv ----
// package: register map, field layout, reset values and carriers for picture adjust
package pac_pkg;
   // register offsets (serial-port destination addresses)
   localparam logic [7:0] PAC_HUE_OFFSET     = 8'h03;
   localparam logic [7:0] PAC_SHARP_OFFSET   = 8'h04;
   localparam logic [7:0] PAC_SAT_OFFSET     = 8'h05;
   localparam logic [7:0] PAC_RATIO_LO_OFFSET = 8'h06;
   localparam logic [7:0] PAC_RATIO_HI_OFFSET = 8'h07;
   // reset values
   localparam logic [7:0] PAC_HUE_RESET      = 8'h00;
   localparam logic [7:0] PAC_SHARP_RESET    = 8'h00;
   localparam logic [7:0] PAC_SAT_RESET      = 8'h9D;
   localparam logic [7:0] PAC_RATIO_LO_RESET = 8'hC1;
   localparam logic [7:0] PAC_RATIO_HI_RESET = 8'h87;
   // sharpness field positions (low bit of each two-bit field)
   localparam int PAC_HF_POS  = 6;
   localparam int PAC_MF_POS  = 4;
   localparam int PAC_LF_POS  = 2;
   localparam int PAC_VHF_POS = 0;
   // band gain codes
   localparam logic [1:0] PAC_GAIN_X1   = 2'h0;
   localparam logic [1:0] PAC_GAIN_X2   = 2'h1;
   localparam logic [1:0] PAC_GAIN_X4   = 2'h2;
   localparam logic [1:0] PAC_GAIN_ZERO = 2'h3;
   // hue step: quarter degree per count
   localparam logic [7:0] PAC_HUE_STEPS_PER_DEG = 8'h04;
   // register write request from the serial port
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } pac_wr_type;
   // one pixel: luma bands and chroma pair (signed, 128-offset removed)
   typedef struct packed {
      logic              valid;
      logic signed [8:0] lumaBase;
      logic signed [8:0] lumaHigh;
      logic signed [8:0] lumaMid;
      logic signed [8:0] lumaLow;
      logic signed [8:0] lumaVert;
      logic signed [7:0] cb;
      logic signed [7:0] cr;
      logic signed [7:0] cosHue;
      logic signed [7:0] sinHue;
   } pac_pix_type;
   typedef struct packed {
      logic       valid;
      logic [7:0] luma;
      logic [7:0] cb;
      logic [7:0] cr;
   } pac_out_type;
endpackage : pac_pkg

// ---- hw/pac_band_gain.sv ----
// one luminance band scaled by a two-bit enhancement code
`timescale 1ns/100ps
`default_nettype none
module pac_band_gain (
   // band sample and code
   input  wire logic signed [8:0]  band,
   input  wire logic        [1:0]  code,
   input  wire logic               vertical,
   // scaled band
   output logic signed [11:0] scaled
);
   import pac_pkg::*;
   // vertical band only knows pass and zero; reserved codes pass through
   always_comb begin
      case (code)
         PAC_GAIN_X1:   scaled = 12'(band);
         PAC_GAIN_X2:   scaled = vertical ? 12'(band) : 12'(band) <<< 1;
         PAC_GAIN_X4:   scaled = vertical ? 12'(band) : 12'(band) <<< 2;
         PAC_GAIN_ZERO: scaled = 12'sh000;
         default:       scaled = 12'(band);
      endcase
   end
endmodule : pac_band_gain
`default_nettype wire

// ---- hw/pac_picture_adjust.sv ----
// picture adjust controls: hue, sharpness, saturation registers and pixel arithmetic
// Notes on behaviour
// - hue register is signed two's complement, +127 to -128 counts.
// - chroma pair rotated by hue count times a quarter degree.
// - bits 7-6 scale horizontal high band by 1, 2, 4 or zero.
// - bits 5-4 scale middle band by 1, 2, 4 or zero.
// - bits 3-2 scale low band by 1, 2, 4 or zero.
// - bits 1-0 pass or remove vertical high band; host avoids codes 01, 10.
// - chroma multiplied by saturation, unsigned fraction 0 to 1.9921875.
// - ratio low byte supplies weights two to minus nine through minus sixteen.
// - ratio low byte resets to the 4 x 3.579545 MHz / 27 MHz value.
// - ratio upper byte comes from companion register, weights half to 1/256.
`timescale 1ns/100ps
`default_nettype none
module pac_picture_adjust (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               reset_n,
   // register writes from the serial port
   input  wire pac_pkg::pac_wr_type regWrite,
   input  wire logic        [7:0]  readAddr,
   // pixel in
   input  wire pac_pkg::pac_pix_type pixIn,
   // register read data and pixel out
   output logic        [7:0]  readData,
   output var pac_pkg::pac_out_type pixOut,
   output logic       [15:0]  chromaRatio,
   output logic signed [7:0]  hueCount
);
   import pac_pkg::*;

   typedef struct packed {
      logic [7:0]  hue;
      logic [7:0]  sharp;
      logic [7:0]  sat;
      logic [7:0]  ratioLo;
      logic [7:0]  ratioHi;
      logic [7:0]  rdData;
      pac_out_type pix;
   } pac_state_type;

   pac_state_type state_reg;
   pac_state_type state_next;

   logic signed [11:0] highScaled;
   logic signed [11:0] midScaled;
   logic signed [11:0] lowScaled;
   logic signed [11:0] vertScaled;
   logic signed [17:0] lumaTotal;

   // clip a signed sum to the legal 8-bit sample range
   function automatic logic [7:0] clipU8(input logic signed [17:0] v);
      if (v < 18'sd0)
         clipU8 = 8'h00;
      else if (v > 18'sd255)
         clipU8 = 8'hFF;
      else
         clipU8 = v[7:0];
   endfunction : clipU8

   // signed chroma back to offset-binary, clipped
   function automatic logic [7:0] clipChroma(input logic signed [17:0] v);
      clipChroma = clipU8(v + 18'sd128);
   endfunction : clipChroma

   // band scaling, one instance per band
   pac_band_gain uHigh (.band(pixIn.lumaHigh), .code(state_reg.sharp[PAC_HF_POS+:2]),
                        .vertical(1'b0), .scaled(highScaled));
   pac_band_gain uMid  (.band(pixIn.lumaMid),  .code(state_reg.sharp[PAC_MF_POS+:2]),
                        .vertical(1'b0), .scaled(midScaled));
   pac_band_gain uLow  (.band(pixIn.lumaLow),  .code(state_reg.sharp[PAC_LF_POS+:2]),
                        .vertical(1'b0), .scaled(lowScaled));
   pac_band_gain uVert (.band(pixIn.lumaVert), .code(state_reg.sharp[PAC_VHF_POS+:2]),
                        .vertical(1'b1), .scaled(vertScaled));

   // luma total before clipping, shared by the pixel path and its checks
   assign lumaTotal = 18'(pixIn.lumaBase) + 18'(highScaled) + 18'(midScaled)
                    + 18'(lowScaled) + 18'(vertScaled);

   // next state: register writes, readback, pixel arithmetic
   always_comb begin
      logic signed [17:0] lumaSum;
      logic signed [17:0] cbRot;
      logic signed [17:0] crRot;
      logic signed [17:0] cbSat;
      logic signed [17:0] crSat;
      lumaSum = 18'sh00000;
      cbRot = 18'sh00000;
      crRot = 18'sh00000;
      cbSat = 18'sh00000;
      crSat = 18'sh00000;
      state_next = state_reg;
      if (regWrite.write) begin
         case (regWrite.addr)
            PAC_HUE_OFFSET:      state_next.hue = regWrite.data;
            PAC_SHARP_OFFSET:    state_next.sharp = regWrite.data;
            PAC_SAT_OFFSET:      state_next.sat = regWrite.data;
            PAC_RATIO_LO_OFFSET: state_next.ratioLo = regWrite.data;
            PAC_RATIO_HI_OFFSET: state_next.ratioHi = regWrite.data;
            default:             state_next.hue = state_reg.hue;
         endcase
      end
      // readback shows stored values; unmapped reads as zero
      case (readAddr)
         PAC_HUE_OFFSET:      state_next.rdData = state_reg.hue;
         PAC_SHARP_OFFSET:    state_next.rdData = state_reg.sharp;
         PAC_SAT_OFFSET:      state_next.rdData = state_reg.sat;
         PAC_RATIO_LO_OFFSET: state_next.rdData = state_reg.ratioLo;
         PAC_RATIO_HI_OFFSET: state_next.rdData = state_reg.ratioHi;
         default:             state_next.rdData = 8'h00;
      endcase
      // luma: base plus scaled bands, clipped rather than wrapped
      lumaSum = lumaTotal;
      // hue rotation: the sin/cos pair (Q1.6) for hue count * 0.25 deg is
      // supplied with the pixel by the demodulator's phase table
      cbRot = (18'(pixIn.cb) * 18'(pixIn.cosHue) + 18'(pixIn.cr) * 18'(pixIn.sinHue)) >>> 6;
      crRot = (18'(pixIn.cr) * 18'(pixIn.cosHue) - 18'(pixIn.cb) * 18'(pixIn.sinHue)) >>> 6;
      // saturation: unsigned Q1.7, clamp rotated value before multiply
      cbSat = (18'(signed'(clipChroma(cbRot) ^ 8'h80)) * $signed({10'h000, state_reg.sat})) >>> 7;
      crSat = (18'(signed'(clipChroma(crRot) ^ 8'h80)) * $signed({10'h000, state_reg.sat})) >>> 7;
      state_next.pix.valid = pixIn.valid;
      state_next.pix.luma = clipU8(lumaSum);
      state_next.pix.cb = clipChroma(cbSat);
      state_next.pix.cr = clipChroma(crSat);
   end

   // single state register; reset brings every control to its defined value
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.hue <= PAC_HUE_RESET;
         state_reg.sharp <= PAC_SHARP_RESET;
         state_reg.sat <= PAC_SAT_RESET;
         state_reg.ratioLo <= PAC_RATIO_LO_RESET;
         state_reg.ratioHi <= PAC_RATIO_HI_RESET;
         state_reg.rdData <= 8'h00;
         state_reg.pix <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign readData = state_reg.rdData;
   assign pixOut = state_reg.pix;
   assign chromaRatio = {state_reg.ratioHi, state_reg.ratioLo};
   assign hueCount = signed'(state_reg.hue);

   // assertions
   a_ratio_reset_value: assert property (@(posedge clock) $rose(reset_n) |-> chromaRatio[7:0] == PAC_RATIO_LO_RESET)
      else $error("ratio low byte not at reset value");
   a_ratio_low_write: assert property (@(posedge clock) disable iff (!reset_n)
      regWrite.write && regWrite.addr == PAC_RATIO_LO_OFFSET |=> chromaRatio[7:0] == $past(regWrite.data))
      else $error("ratio low byte write lost");
   a_ratio_high_write: assert property (@(posedge clock) disable iff (!reset_n)
      regWrite.write && regWrite.addr == PAC_RATIO_HI_OFFSET |=> chromaRatio[15:8] == $past(regWrite.data))
      else $error("ratio high byte write lost");
   a_hue_sign: assert property (@(posedge clock) disable iff (!reset_n)
      regWrite.write && regWrite.addr == PAC_HUE_OFFSET && regWrite.data[7] |=> hueCount < 0)
      else $error("hue sign bit not negative");
   a_high_zero: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[7:6] == PAC_GAIN_ZERO |-> highScaled == 12'sh000)
      else $error("high band not zeroed");
   a_mid_gain: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[5:4] == PAC_GAIN_X2 |-> midScaled == 12'(pixIn.lumaMid) * 12'sd2)
      else $error("middle band gain wrong");
   a_low_gain: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[3:2] == PAC_GAIN_X4 |-> lowScaled == 12'(pixIn.lumaLow) * 12'sd4)
      else $error("low band gain wrong");
   a_vert_pass: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[1:0] == PAC_GAIN_X1 |-> vertScaled == 12'(pixIn.lumaVert))
      else $error("vertical band not passed");
   a_sat_zero: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sat == 8'h00 && pixIn.valid |=> pixOut.cb == 8'h80 && pixOut.cr == 8'h80)
      else $error("zero saturation left chroma");
   a_hue_identity: assert property (@(posedge clock) disable iff (!reset_n)
      pixIn.valid && pixIn.sinHue == 8'sh00 && pixIn.cosHue == 8'sh40 && state_reg.sat == 8'h80
      |=> pixOut.cb == $past(pixIn.cb) + 8'h80)
      else $error("zero hue changed chroma");
   a_luma_clip: assert property (@(posedge clock) disable iff (!reset_n)
      pixIn.valid && lumaTotal > 18'sd255 |=> pixOut.luma == 8'hFF)
      else $error("luma wrapped instead of clipping");
   a_luma_floor: assert property (@(posedge clock) disable iff (!reset_n)
      pixIn.valid && lumaTotal < 18'sd0 |=> pixOut.luma == 8'h00)
      else $error("negative luma not clipped to zero");

   // control writes land one cycle later
   a_hue_write: assert property (@(posedge clock) disable iff (!reset_n)
      regWrite.write && regWrite.addr == PAC_HUE_OFFSET |=> hueCount == signed'($past(regWrite.data)))
      else $error("hue write lost");
   a_sat_write: assert property (@(posedge clock) disable iff (!reset_n)
      regWrite.write && regWrite.addr == PAC_SAT_OFFSET |=> state_reg.sat == $past(regWrite.data))
      else $error("saturation write lost");
   a_sharp_write: assert property (@(posedge clock) disable iff (!reset_n)
      regWrite.write && regWrite.addr == PAC_SHARP_OFFSET |=> state_reg.sharp == $past(regWrite.data))
      else $error("sharpness write lost");

   // band gains against the code table
   a_high_gain: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[7:6] == PAC_GAIN_X4 |-> highScaled == 12'(pixIn.lumaHigh) * 12'sd4)
      else $error("high band gain wrong");
   a_mid_zero: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[5:4] == PAC_GAIN_ZERO |-> midScaled == 12'sh000)
      else $error("middle band not zeroed");
   a_low_pass: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[3:2] == PAC_GAIN_X1 |-> lowScaled == 12'(pixIn.lumaLow))
      else $error("low band not passed");
   a_vert_zero: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.sharp[1:0] == PAC_GAIN_ZERO |-> vertScaled == 12'sh000)
      else $error("vertical band not removed");

   // readback and hold: the ratio feeds the chroma loop, so it must not drift
   a_read_hue: assert property (@(posedge clock) disable iff (!reset_n)
      readAddr == PAC_HUE_OFFSET |=> readData == $past(state_reg.hue))
      else $error("hue readback wrong");
   a_read_ratio: assert property (@(posedge clock) disable iff (!reset_n)
      readAddr == PAC_RATIO_LO_OFFSET |=> readData == $past(chromaRatio[7:0]))
      else $error("ratio low readback wrong");
   a_ratio_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !(regWrite.write && (regWrite.addr == PAC_RATIO_LO_OFFSET || regWrite.addr == PAC_RATIO_HI_OFFSET))
      |=> $stable(chromaRatio))
      else $error("ratio changed without a write");
   a_hue_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !(regWrite.write && regWrite.addr == PAC_HUE_OFFSET) |=> $stable(hueCount))
      else $error("hue changed without a write");
endmodule : pac_picture_adjust
`default_nettype wire

// ---- verification/pac_host_model.sv ----
// host model: serial-port register writer for the picture adjust block
`timescale 1ns/100ps
`default_nettype none
module pac_host_model
   import pac_pkg::*;
#(
   parameter logic [15:0] RATIO_FOR_CLOCK = 16'h87C1
) (
   // clock
   input  wire logic            clock,
   // write request
   output var pac_pkg::pac_wr_type regWrite
);
   initial regWrite = '0;
   // one write, raised after a falling edge and held across one rising edge
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      // reserved vertical codes are never sent, so the design's handling of them stays untested
      if (addr == PAC_SHARP_OFFSET && (data[1:0] == 2'h1 || data[1:0] == 2'h2)) begin
         return;
      end
      @(negedge clock);
      regWrite <= '{write: 1'b1, addr: addr, data: data};
      @(negedge clock);
      regWrite <= '0;
   endtask : write_reg
   // both ratio bytes come from one figure matched to the supplied clock
   task automatic program_ratio();
      write_reg(PAC_RATIO_LO_OFFSET, RATIO_FOR_CLOCK[7:0]);
      write_reg(PAC_RATIO_HI_OFFSET, RATIO_FOR_CLOCK[15:8]);
   endtask : program_ratio
endmodule : pac_host_model
`default_nettype wire

// ---- verification/pac_picture_adjust_test.sv ----
// self-checking bench for the picture adjust registers and pixel path
`timescale 1ns/100ps
`default_nettype none
module pac_picture_adjust_test;
   import pac_pkg::*;
   localparam logic [15:0] TEST_RATIO = 16'h9A3C;
   logic                clock;
   logic                reset_n;
   pac_wr_type          regWrite;
   logic        [7:0]   readAddr;
   pac_pix_type         pixIn;
   logic        [7:0]   readData;
   pac_out_type         pixOut;
   logic        [15:0]  chromaRatio;
   logic signed [7:0]   hueCount;
   int                  num_errors;
   int                  compares;
   int                  gain [4] = '{1, 2, 4, 0};
   logic        [7:0]   satVal [4] = '{8'h80, 8'h40, 8'h00, 8'hFF};
   int                  satIn [4] = '{40, 40, 40, 100};
   logic        [7:0]   satCb [4] = '{8'hA8, 8'h94, 8'h80, 8'hFF};
   logic        [7:0]   satCr [4] = '{8'h58, 8'h6C, 8'h80, 8'h00};
   logic        [7:0]   hueVal [3] = '{8'h7F, 8'h80, 8'hFF};

   pac_host_model #(.RATIO_FOR_CLOCK(TEST_RATIO)) u_host (.clock(clock), .regWrite(regWrite));
   pac_picture_adjust u_dut (.clock(clock), .reset_n(reset_n), .regWrite(regWrite), .readAddr(readAddr),
      .pixIn(pixIn), .readData(readData), .pixOut(pixOut), .chromaRatio(chromaRatio), .hueCount(hueCount));

   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // readback: address held over one rising edge, data taken after it
   task automatic check_reg(input string name, input logic [7:0] addr, input logic [7:0] exp);
      @(negedge clock);
      readAddr = addr;
      @(negedge clock);
      check(name, {8'h00, readData}, {8'h00, exp});
   endtask : check_reg

   // one pixel with unit rotation (cos 1.0, sin 0); cr is the negated cb
   task automatic run_pix(input int b, input int h, input int m, input int l, input int v, input int c,
                          input logic [7:0] eLuma, input logic [7:0] eCb, input logic [7:0] eCr);
      @(negedge clock);
      pixIn = '{valid: 1'b1, lumaBase: 9'(b), lumaHigh: 9'(h), lumaMid: 9'(m), lumaLow: 9'(l),
                lumaVert: 9'(v), cb: 8'(c), cr: 8'(-c), cosHue: 8'h40, sinHue: 8'h00};
      @(negedge clock);
      pixIn.valid = 1'b0;
      check("pixel valid", {15'h0000, pixOut.valid}, 16'h0001);
      check("pixel luma", {8'h00, pixOut.luma}, {8'h00, eLuma});
      check("pixel cb", {8'h00, pixOut.cb}, {8'h00, eCb});
      check("pixel cr", {8'h00, pixOut.cr}, {8'h00, eCr});
   endtask : run_pix

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      report_and_stop();
   end

   initial begin
      num_errors = 0;
      compares = 0;
      reset_n = 1'b0;
      readAddr = 8'h00;
      pixIn = '0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      check("ratio at reset", chromaRatio, 16'h87C1);
      check("hue at reset", 16'(hueCount), 16'h0000);
      check_reg("hue reg", 8'h03, 8'h00);
      check_reg("sharp reg", 8'h04, 8'h00);
      check_reg("sat reg", 8'h05, 8'h9D);
      check_reg("ratio low", 8'h06, 8'hC1);
      check_reg("ratio high", 8'h07, 8'h87);
      u_host.write_reg(8'h08, 8'h5A);
      check_reg("unmapped", 8'h08, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         u_host.write_reg(8'h03, hueVal[i]);
         @(negedge clock);
         check("hue count", 16'(hueCount), {{8{hueVal[i][7]}}, hueVal[i]});
         check_reg("hue readback", 8'h03, hueVal[i]);
      end
      $display("test hue done");
      u_host.program_ratio();
      @(negedge clock);
      check("ratio programmed", chromaRatio, TEST_RATIO);
      check_reg("ratio low back", 8'h06, TEST_RATIO[7:0]);
      check_reg("ratio high back", 8'h07, TEST_RATIO[15:8]);
      // mid-run reset must bring the programmed ratio back to its default
      reset_n = 1'b0;
      @(negedge clock);
      reset_n = 1'b1;
      check("ratio after reset", chromaRatio, 16'h87C1);
      check("hue after reset", 16'(hueCount), 16'h0000);
      $display("test ratio done");
      for (int i = 0; i < 4; i++) begin
         u_host.write_reg(8'h05, satVal[i]);
         run_pix(100, 0, 0, 0, 0, satIn[i], 8'h64, satCb[i], satCr[i]);
      end
      $display("test saturation done");
      // unity saturation, so the sharpness runs keep the plain chroma figures
      u_host.write_reg(8'h05, 8'h80);
      for (int k = 0; k < 4; k++) begin
         u_host.write_reg(8'h04, {2'(k), 2'(k), 2'(k), (k == 3) ? 2'h3 : 2'h0});
         run_pix(100, 10, 5, 3, 1, 40, 8'(100 + gain[k] * 18 + ((k == 3) ? 0 : 1)), 8'hA8, 8'h58);
      end
      u_host.write_reg(8'h04, 8'h1B);
      run_pix(100, 10, 5, 3, 1, 40, 8'd132, 8'hA8, 8'h58);
      check_reg("sharp readback", 8'h04, 8'h1B);
      u_host.write_reg(8'h04, 8'h80);
      run_pix(250, 100, 0, 0, 0, 40, 8'hFF, 8'hA8, 8'h58);
      u_host.write_reg(8'h04, 8'hFF);
      run_pix(-50, 100, 100, 100, 100, 40, 8'h00, 8'hA8, 8'h58);
      // quarter-turn rotation: cb takes cr, cr takes minus cb
      @(negedge clock);
      pixIn = '{valid: 1'b1, lumaBase: 9'(100), lumaHigh: 9'(0), lumaMid: 9'(0), lumaLow: 9'(0),
                lumaVert: 9'(0), cb: 8'(40), cr: 8'(-40), cosHue: 8'h00, sinHue: 8'h40};
      @(negedge clock);
      pixIn.valid = 1'b0;
      check("rotated cb", {8'h00, pixOut.cb}, 16'h0058);
      check("rotated cr", {8'h00, pixOut.cr}, 16'h0058);
      $display("test sharpness done");
      report_and_stop();
   end
endmodule : pac_picture_adjust_test
`default_nettype wire
